// >>> dv/rtcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: register cycles and trigger pin setup
module rtcf_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // trigger pin setup
  output logic [1:0] trigger_pin_io_mode,
  output logic trigger_pin_polarity
);
  // idle values at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    trigger_pin_io_mode = 2'h0;
    trigger_pin_polarity = 1'b0;
  end

  // one write, taken at the single rising edge in between
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : write

  // one read, data settled half a cycle after the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : read

  // io mode first, polarity after it
  task automatic set_pin(input logic [1:0] m, input logic p);
    @(negedge clk);
    trigger_pin_io_mode = m;
    @(negedge clk);
    trigger_pin_polarity = p;
  endtask : set_pin
endmodule : rtcf_host_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // stimulus, crystal stand-in toggles every cycle
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic xtal_32k = 1'b0;
  logic halt_count = 1'b0;
  logic [1:0] irq_a_pin_mode = 2'h0;
  logic clock_pin_disable = 1'b0;
  logic clkout_invert = 1'b0;
  logic periodic_irq_flag_clear = 1'b0;
  logic trigger_pin = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, v;
  logic reg_wr, reg_rd, bad, exp_en;
  logic [1:0] tmode;
  logic tpol, count_enable, count_mode_select, hundredths_enable, second_tick;
  logic hundredths_tick, periodic_irq_pulse, periodic_irq_flag, clk_pin;
  logic trigger_pin_out, trigger_pin_oe, irq_a_pin_out, irq_a_pin_oe;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int hi, rises, n, ticks;

  always #12.5 clk = ~clk;
  always @(negedge clk) xtal_32k <= ~xtal_32k;

  rtcf_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .trigger_pin_io_mode(tmode),
    .trigger_pin_polarity(tpol));

  rtcf_function_control #(.PRESC_W(15)) DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .xtal_32k(xtal_32k), .halt_count(halt_count), .trigger_pin_io_mode(tmode),
    .trigger_pin_polarity(tpol), .irq_a_pin_mode(irq_a_pin_mode),
    .clock_pin_disable(clock_pin_disable), .clkout_invert(clkout_invert),
    .periodic_irq_flag_clear(periodic_irq_flag_clear), .trigger_pin(trigger_pin),
    .count_enable(count_enable), .count_mode_select(count_mode_select),
    .hundredths_enable(hundredths_enable), .second_tick(second_tick),
    .hundredths_tick(hundredths_tick), .periodic_irq_pulse(periodic_irq_pulse),
    .periodic_irq_flag(periodic_irq_flag), .clk_pin(clk_pin),
    .trigger_pin_out(trigger_pin_out), .trigger_pin_oe(trigger_pin_oe),
    .irq_a_pin_out(irq_a_pin_out), .irq_a_pin_oe(irq_a_pin_oe));

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // expected counting state from halt and pin stop
  function automatic logic exp_count(logic h, logic s, logic [1:0] m, logic p, logic pin);
    return !(h | (s & (m == rtcf_pkg::TSIO_IN) & (pin ^ p)));
  endfunction : exp_count

  // 256 cycles of clock pin after one settling cycle: high time, rising edges, pin agreement
  task automatic measure();
    hi = 0;
    rises = 0;
    bad = 1'b0;
    @(negedge clk);
    rd = {7'h00, clk_pin};
    for (n = 0; n < 256; n++)
    begin
      @(negedge clk);
      bad = bad | (trigger_pin_out !== clk_pin) | (irq_a_pin_oe !== ~clk_pin);
      if (clk_pin === 1'b1)
        hi++;
      if (clk_pin === 1'b1 && rd === 8'h00)
        rises++;
      rd = {7'h00, clk_pin};
    end
  endtask : measure

  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(94867));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    // defaults: register clear, clock pin at crystal rate
    host.read(rtcf_pkg::FUNC_ADDR, rd);
    check(rd, rtcf_pkg::FUNC_RESET, "reset value");
    host.set_pin(rtcf_pkg::TSIO_CLK, 1'b0);
    measure();
    check(8'(rises), 8'h80, "default clock");
    $display("test defaults done");
    // random register values, then an unmapped place
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom());
      host.write(rtcf_pkg::FUNC_ADDR, v);
      host.read(rtcf_pkg::FUNC_ADDR, rd);
      check(rd, v, "readback");
      check({7'h00, count_mode_select}, {7'h00, v[rtcf_pkg::MODE_BIT]}, "mode");
      check({7'h00, hundredths_enable}, {7'h00, v[rtcf_pkg::HUND_BIT]}, "hund");
    end
    host.write(8'h29, ~v);
    host.read(rtcf_pkg::FUNC_ADDR, rd);
    check(rd, v, "unmapped write");
    host.read(8'h29, rd);
    check(rd, 8'h00, "unmapped read");
    $display("test registers done");
    // codes 0 to 5 (crystal and first five divided): rate, 50:50 duty on divided codes, same wave on all pins
    for (int c = 0; c < 6; c++)
    begin
      host.write(rtcf_pkg::FUNC_ADDR, {5'h00, 3'(c)});
      measure();
      check(8'(rises), 8'h80 >> c, "rate");
      check({7'h00, bad}, 8'h00, "pins agree");
      if (c > 0)
        check(8'(hi), 8'h80, "duty");
      else
        check({7'h00, hi > 102 && hi < 154}, 8'h01, "duty");
    end
    check({7'h00, trigger_pin_oe}, 8'h01, "ts drive");
    clkout_invert = 1'b1;
    host.write(rtcf_pkg::FUNC_ADDR, {5'h00, rtcf_pkg::COF_OFF});
    measure();
    check({7'h00, hi != 0 || trigger_pin_out !== 1'b0}, 8'h00, "static low");
    check({7'h00, irq_a_pin_oe}, 8'h00, "irq a released");
    check({7'h00, irq_a_pin_out}, 8'h00, "irq a level");
    clkout_invert = 1'b0;
    clock_pin_disable = 1'b1;
    host.write(rtcf_pkg::FUNC_ADDR, 8'h00);
    measure();
    check({7'h00, hi != 0}, 8'h00, "pin disabled");
    clock_pin_disable = 1'b0;
    $display("test clock output done");
    // random stop sources
    for (int i = 0; i < 24; i++)
    begin
      v = 8'($urandom());
      host.write(rtcf_pkg::FUNC_ADDR, {4'h0, v[0], 3'h0});
      host.set_pin(v[2:1], v[3]);
      halt_count = v[4] & v[5];
      trigger_pin = v[6];
      exp_en = exp_count(halt_count, v[0], v[2:1], v[3], v[6]);
      repeat (3) @(negedge clk);
      check({7'h00, count_enable}, {7'h00, exp_en}, "count");
    end
    $display("test stop control done");
    // hundredths running: 25 steps in every 64 ticks of 256 Hz
    halt_count = 1'b0;
    host.write(rtcf_pkg::FUNC_ADDR, 8'h80);
    repeat (2) @(negedge clk);
    ticks = 0;
    repeat (16384)
    begin
      @(negedge clk);
      if (hundredths_tick === 1'b1)
        ticks++;
    end
    check(8'(ticks), 8'h19, "hundredths");
    $display("test hundredths done");
    // second pulse while halted at 1 Hz clock: timers keep running, ticks stay off
    halt_count = 1'b1;
    ticks = 0;
    hi = 0;
    rises = 0;
    rd = 8'h01;
    host.write(rtcf_pkg::FUNC_ADDR, {1'b0, rtcf_pkg::PI_SEC, 2'h0, rtcf_pkg::COF_1HZ});
    for (n = 0; n < 65600 && periodic_irq_pulse !== 1'b1; n++)
    begin
      @(negedge clk);
      if (second_tick === 1'b1)
        ticks++;
      if (clk_pin === 1'b1)
        hi++;
      if (clk_pin === 1'b1 && rd[0] === 1'b0)
        rises++;
      rd = {7'h00, clk_pin};
    end
    check(8'(rises), 8'h01, "one hertz edge");
    check({7'h00, hi > 32760 && hi < 32776}, 8'h01, "one hertz duty");
    check({7'h00, periodic_irq_pulse}, 8'h01, "first pulse");
    check({7'h00, periodic_irq_flag}, 8'h01, "flag set");
    check(8'(ticks), 8'h00, "halted ticks");
    periodic_irq_flag_clear = 1'b1;
    @(negedge clk);
    periodic_irq_flag_clear = 1'b0;
    @(negedge clk);
    check({7'h00, periodic_irq_flag}, 8'h00, "flag cleared");
    $display("test periodic done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// >>> pkg/rtcf_pkg.sv
`default_nettype none
package rtcf_pkg;

  // ----------------------------------------------------------------
  // function control register
  // ----------------------------------------------------------------
  localparam logic [7:0] FUNC_ADDR = 8'h28;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam int HUND_BIT = 7;
  localparam int PI_LSB = 5;
  localparam int MODE_BIT = 4;
  localparam int STOPSRC_BIT = 3;
  localparam int COF_LSB = 0;

  // periodic interrupt selector codes
  localparam logic [1:0] PI_OFF = 2'h0;
  localparam logic [1:0] PI_SEC = 2'h1;
  localparam logic [1:0] PI_MIN = 2'h2;
  localparam logic [1:0] PI_HOUR = 2'h3;

  // periodic interval lengths in seconds
  localparam logic [11:0] SECS_PER_MIN = 12'h03c;
  localparam logic [11:0] SECS_PER_HOUR = 12'he10;

  // clock output selector codes
  localparam logic [2:0] COF_XTAL = 3'h0;
  localparam logic [2:0] COF_1HZ = 3'h6;
  localparam logic [2:0] COF_OFF = 3'h7;
  localparam int ONE_HZ_BIT = 14;

  // trigger pin io modes
  localparam logic [1:0] TSIO_CLK = 2'h2;
  localparam logic [1:0] TSIO_IN = 2'h3;
  // interrupt-a pin mode that carries the clock
  localparam logic [1:0] IRQA_CLK = 2'h0;

  // hundredths divider: 14 periods of /3 then 11 periods of /2
  localparam logic [4:0] HUND_LONG = 5'h0e;
  localparam logic [4:0] HUND_LAST = 5'h18;
  localparam logic [6:0] TICK256_MASK = 7'h7f;

  // ----------------------------------------------------------------
  // module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] func;        // function control register
    logic [7:0] rdata;       // read data
    logic xtal_d;            // previous crystal level
    logic [14:0] presc;      // crystal prescaler
    logic [11:0] per_cnt;    // periodic interval seconds
    logic [1:0] hdiv;        // hundredths sub-divider
    logic [4:0] hidx;        // hundredths phase index
    logic pi_pulse;          // periodic interrupt pulse
    logic pi_flag;           // periodic interrupt flag
    logic count_en;          // time counting runs
    logic sec_tick;          // gated seconds tick
    logic hund_tick;         // gated hundredths tick
    logic clk_pin;           // dedicated clock pin level
    logic ts_out;            // trigger pin clock level
    logic ts_oe;             // trigger pin drive enable
    logic irqa_oe;           // interrupt-a pull-down enable
  } rtcf_state_t;

endpackage : rtcf_pkg
`default_nettype wire

// >>> rtl/rtcf_function_control.sv
// Behaviour
// - selector picks none, second, minute, hour pulses
// - disabled selector holds periodic timers reset
// - first pulse within period, not before period-1s
// - periodic timers ignore halt and pin stop
// - each periodic pulse sets the periodic flag
// - pulses continue while flag stays uncleared
// - periodic interval uses uncalibrated crystal seconds
// - mode bit 0 selects calendar counting
// - mode bit 1 selects elapsed hour counting
// - stop source bit adds trigger pin stop
// - halt bit stops counting in both modes
// - pin active level stops, halt overrides pin
// - selector gives seven frequencies or static off
// - clock pin push-pull, on at 32.768 kHz
// - clock pin disable drives the pin low
// - same square wave on trigger and irq-a pins
// - invert bit inverts, except for static off
// - divided outputs keep a 50:50 duty
// - polarity bit 0 active high, 1 active low
`timescale 1ns/1ps
`default_nettype none
module rtcf_function_control #(
  parameter int PRESC_W = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // crystal oscillator level
  input wire logic xtal_32k,
  // control bits from neighbouring registers
  input wire logic halt_count,
  input wire logic [1:0] trigger_pin_io_mode,
  input wire logic trigger_pin_polarity,
  input wire logic [1:0] irq_a_pin_mode,
  input wire logic clock_pin_disable,
  input wire logic clkout_invert,
  input wire logic periodic_irq_flag_clear,
  // trigger pin input level
  input wire logic trigger_pin,
  // counting control to the time counter chain
  output logic count_enable,
  output logic count_mode_select,
  output logic hundredths_enable,
  output logic second_tick,
  output logic hundredths_tick,
  // periodic interrupt
  output logic periodic_irq_pulse,
  output logic periodic_irq_flag,
  // clock outputs
  output logic clk_pin,
  output logic trigger_pin_out,
  output logic trigger_pin_oe,
  output logic irq_a_pin_out,
  output logic irq_a_pin_oe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (PRESC_W != 15)
  begin : g_bad_presc
    $error("prescaler must be 15 bits to reach 1 Hz");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // last count of the periodic interval for a selector code
  function automatic logic [11:0] period_last(input logic [1:0] sel);
    logic [11:0] v;
    v = 12'h000;
    unique case (sel)
      rtcf_pkg::PI_MIN: v = rtcf_pkg::SECS_PER_MIN - 12'h001;
      rtcf_pkg::PI_HOUR: v = rtcf_pkg::SECS_PER_HOUR - 12'h001;
      rtcf_pkg::PI_SEC: v = 12'h000;
      rtcf_pkg::PI_OFF: v = 12'h000;
    endcase
    return v;
  endfunction : period_last

  rtcf_pkg::rtcf_state_t st_r;   // registered state
  rtcf_pkg::rtcf_state_t st_nxt; // next state

  // field views of the function register
  logic [1:0] pi_sel;
  logic [2:0] cof;
  logic stop_src;
  assign pi_sel = st_r.func[rtcf_pkg::PI_LSB +: 2];
  assign cof = st_r.func[rtcf_pkg::COF_LSB +: 3];
  assign stop_src = st_r.func[rtcf_pkg::STOPSRC_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // crystal edge, 1 Hz and 256 Hz ticks, stop decision, waves
  always_comb
  begin
    logic xtal_rise;
    logic raw_sec;
    logic tick256;
    logic pin_active;
    logic stopped;
    logic hund_step;
    logic wave;
    logic wave_pol;
    xtal_rise = 1'b0;
    raw_sec = 1'b0;
    tick256 = 1'b0;
    pin_active = 1'b0;
    stopped = 1'b0;
    hund_step = 1'b0;
    wave = 1'b0;
    wave_pol = 1'b0;
    st_nxt = st_r;

    // register write and read, unmapped reads give zero
    if (reg_wr && reg_addr == rtcf_pkg::FUNC_ADDR)
    begin
      st_nxt.func = reg_wdata;
    end
    if (reg_rd)
    begin
      st_nxt.rdata = (reg_addr == rtcf_pkg::FUNC_ADDR) ? st_r.func : 8'h00;
    end

    // free-running prescaler on raw crystal edges
    xtal_rise = xtal_32k && !st_r.xtal_d;
    st_nxt.xtal_d = xtal_32k;
    if (xtal_rise)
    begin
      st_nxt.presc = st_r.presc + 15'h0001;
    end
    raw_sec = xtal_rise && (&st_r.presc);
    tick256 = xtal_rise && (st_r.presc[6:0] == rtcf_pkg::TICK256_MASK);

    // periodic timers never see the stop decision
    st_nxt.pi_pulse = 1'b0;
    if (pi_sel == rtcf_pkg::PI_OFF)
    begin
      st_nxt.per_cnt = 12'h000;
    end
    else if (raw_sec)
    begin
      if (st_r.per_cnt >= period_last(pi_sel))
      begin
        st_nxt.per_cnt = 12'h000;
        st_nxt.pi_pulse = 1'b1;
      end
      else
      begin
        st_nxt.per_cnt = st_r.per_cnt + 12'h001;
      end
    end

    // flag: a new event beats a clear in the same cycle
    if (st_nxt.pi_pulse)
    begin
      st_nxt.pi_flag = 1'b1;
    end
    else if (periodic_irq_flag_clear)
    begin
      st_nxt.pi_flag = 1'b0;
    end

    // stop decision: halt always, pin only when selected and an input
    pin_active = trigger_pin ^ trigger_pin_polarity;
    stopped = halt_count
      || (stop_src && trigger_pin_io_mode == rtcf_pkg::TSIO_IN
          && pin_active);
    st_nxt.count_en = !stopped;

    // hundredths divider from 256 Hz, 3 and 2 pattern over 25 steps
    if (tick256)
    begin
      if (st_r.hdiv == ((st_r.hidx < rtcf_pkg::HUND_LONG) ? 2'h2 : 2'h1))
      begin
        st_nxt.hdiv = 2'h0;
        hund_step = 1'b1;
        st_nxt.hidx = (st_r.hidx == rtcf_pkg::HUND_LAST) ? 5'h00
          : st_r.hidx + 5'h01;
      end
      else
      begin
        st_nxt.hdiv = st_r.hdiv + 2'h1;
      end
    end

    // ticks to the counter chain, gated by the stop decision
    st_nxt.sec_tick = raw_sec && !stopped;
    st_nxt.hund_tick = hund_step && !stopped
      && st_r.func[rtcf_pkg::HUND_BIT];

    // square wave: prescaler bits toggle evenly, so duty is 50:50
    unique case (cof)
      rtcf_pkg::COF_XTAL: wave = xtal_32k;
      rtcf_pkg::COF_1HZ: wave = st_r.presc[rtcf_pkg::ONE_HZ_BIT];
      rtcf_pkg::COF_OFF: wave = 1'b0;
      default: wave = st_r.presc[cof - 3'h1];
    endcase
    wave_pol = (cof == rtcf_pkg::COF_OFF) ? 1'b0
      : wave ^ clkout_invert;

    // dedicated pin, trigger pin and open-drain interrupt-a pin
    st_nxt.clk_pin = clock_pin_disable ? 1'b0 : wave_pol;
    st_nxt.ts_oe = (trigger_pin_io_mode == rtcf_pkg::TSIO_CLK);
    st_nxt.ts_out = st_nxt.ts_oe && wave_pol;
    st_nxt.irqa_oe = (irq_a_pin_mode == rtcf_pkg::IRQA_CLK)
      && (cof != rtcf_pkg::COF_OFF) && !wave_pol;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset to defaults, 32.768 kHz selected
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.func <= rtcf_pkg::FUNC_RESET;
      st_r.count_en <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign count_enable = st_r.count_en;
  assign count_mode_select = st_r.func[rtcf_pkg::MODE_BIT];
  assign hundredths_enable = st_r.func[rtcf_pkg::HUND_BIT];
  assign second_tick = st_r.sec_tick;
  assign hundredths_tick = st_r.hund_tick;
  assign periodic_irq_pulse = st_r.pi_pulse;
  assign periodic_irq_flag = st_r.pi_flag;
  assign clk_pin = st_r.clk_pin;
  assign trigger_pin_out = st_r.ts_out;
  assign trigger_pin_oe = st_r.ts_oe;
  assign irq_a_pin_out = 1'b0;
  assign irq_a_pin_oe = st_r.irqa_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pi_off_reset: assert property (@(posedge clk) disable iff (!nrst)
    pi_sel == rtcf_pkg::PI_OFF |=> st_r.per_cnt == 12'h000 && !st_r.pi_pulse)
    else $error("periodic timer not held in reset");

  a_pi_sec_pulse: assert property (@(posedge clk) disable iff (!nrst)
    pi_sel == rtcf_pkg::PI_SEC && xtal_32k && !st_r.xtal_d && (&st_r.presc)
    |=> periodic_irq_pulse)
    else $error("missing once per second pulse");

  a_pi_min_count: assert property (@(posedge clk) disable iff (!nrst)
    periodic_irq_pulse && $past(pi_sel) == rtcf_pkg::PI_MIN
    |-> $past(st_r.per_cnt) >= 12'h03b)
    else $error("minute pulse before 59 counted seconds");

  a_pi_ignore_halt: assert property (@(posedge clk) disable iff (!nrst)
    pi_sel == rtcf_pkg::PI_SEC && halt_count && xtal_32k && !st_r.xtal_d
    && (&st_r.presc) |=> periodic_irq_pulse && !second_tick)
    else $error("periodic timer affected by halt");

  a_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    periodic_irq_pulse |-> periodic_irq_flag)
    else $error("flag not set by periodic pulse");

  a_pulse_with_flag: assert property (@(posedge clk) disable iff (!nrst)
    periodic_irq_flag && pi_sel == rtcf_pkg::PI_SEC && xtal_32k
    && !st_r.xtal_d && (&st_r.presc) |=> periodic_irq_pulse)
    else $error("pulse suppressed by pending flag");

  a_halt_stops: assert property (@(posedge clk) disable iff (!nrst)
    halt_count |=> !count_enable ##0 !second_tick)
    else $error("halt did not stop counting");

  a_pin_stops: assert property (@(posedge clk) disable iff (!nrst)
    stop_src && trigger_pin_io_mode == rtcf_pkg::TSIO_IN
    && (trigger_pin != trigger_pin_polarity) |=> !count_enable)
    else $error("active trigger level did not stop counting");

  a_pin_ignored: assert property (@(posedge clk) disable iff (!nrst)
    !stop_src && !halt_count |=> count_enable)
    else $error("counting stopped without halt");

  a_clk_disabled: assert property (@(posedge clk) disable iff (!nrst)
    clock_pin_disable [*2] |-> !clk_pin)
    else $error("disabled clock pin not low");

  a_cof_static: assert property (@(posedge clk) disable iff (!nrst)
    cof == rtcf_pkg::COF_OFF && clkout_invert
    |=> !clk_pin && !irq_a_pin_oe && !trigger_pin_out)
    else $error("static setting inverted or driven");

  a_ts_clock: assert property (@(posedge clk) disable iff (!nrst)
    trigger_pin_io_mode == rtcf_pkg::TSIO_CLK && !clock_pin_disable
    |=> trigger_pin_oe && trigger_pin_out == clk_pin)
    else $error("trigger pin clock differs from clock pin");

  a_hund_gated: assert property (@(posedge clk) disable iff (!nrst)
    hundredths_tick |-> count_enable && $past(st_r.func[rtcf_pkg::HUND_BIT]))
    else $error("hundredths tick while disabled or stopped");

  a_sec_gated: assert property (@(posedge clk) disable iff (!nrst)
    second_tick |-> count_enable)
    else $error("seconds tick while counting stopped");

  a_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    periodic_irq_flag_clear |=> periodic_irq_pulse || !periodic_irq_flag)
    else $error("flag kept after clear without a new pulse");

  a_mode_write: assert property (@(posedge clk) disable iff (!nrst)
    reg_wr && reg_addr == rtcf_pkg::FUNC_ADDR
    |=> count_mode_select == $past(reg_wdata[rtcf_pkg::MODE_BIT])
    && hundredths_enable == $past(reg_wdata[rtcf_pkg::HUND_BIT]))
    else $error("mode or hundredths bit not taken from write");

  a_per_bound: assert property (@(posedge clk) disable iff (!nrst)
    st_r.per_cnt < rtcf_pkg::SECS_PER_HOUR)
    else $error("periodic count beyond one hour");

  a_ts_released: assert property (@(posedge clk) disable iff (!nrst)
    trigger_pin_io_mode != rtcf_pkg::TSIO_CLK |=> !trigger_pin_oe && !trigger_pin_out)
    else $error("trigger pin driven outside clock mode");

  a_irqa_clock: assert property (@(posedge clk) disable iff (!nrst)
    irq_a_pin_mode == rtcf_pkg::IRQA_CLK && cof != rtcf_pkg::COF_OFF
    && !clock_pin_disable |=> irq_a_pin_oe == !clk_pin)
    else $error("interrupt-a clock differs from clock pin");

  a_xtal_invert: assert property (@(posedge clk) disable iff (!nrst)
    cof == rtcf_pkg::COF_XTAL && !clock_pin_disable
    |=> clk_pin == ($past(xtal_32k) ^ $past(clkout_invert)))
    else $error("crystal rate clock not inverted as selected");

endmodule : rtcf_function_control
`default_nettype wire
